// ===== src/bch_regs.vh
`ifndef BCH_REGS_VH
`define BCH_REGS_VH
// Timing counts at 50 MHz
`define BCH_CLK_MHZ 50
`define BCH_INIT_US 10
`define BCH_INIT_CYC (`BCH_INIT_US * `BCH_CLK_MHZ)
`define BCH_TRAIN_CYC 64
// DPCD addresses
`define BCH_DPCD_MAX_LANE 20'h00002
`define BCH_DPCD_LANE_SET 20'h00101
`define BCH_DPCD_TRAIN_PAT 20'h00102
`define BCH_DPCD_LANE_STAT 20'h00202
`define BCH_DPCD_VEND_BASE 20'h00510
`define BCH_VEND_REGS 8
// Reset values and fields
`define BCH_MAX_LANE_RST 8'h02
`define BCH_ENH_FRAME_BIT 7
`define BCH_ASSR_BIT 0
`define BCH_AUX_NATIVE 1'b0
`define BCH_AUX_I2C 1'b1
`endif

// ===== src/bch_trainer.v
`timescale 1ns/1ps
`include "bch_regs.vh"
module bch_trainer
(
   input wire clock,
   input wire run,
   input wire [1:0] pattern,
   input wire fast_mode,
   output reg [3:0] eq_setting,
   output reg locked
);
   localparam [31:0] TRAIN_LAST = `BCH_TRAIN_CYC - 1;
   reg [7:0] count;
   always @(posedge clock)
   begin
      if (!run || pattern == 2'h0)
      begin
         count <= 8'h00;
         locked <= 1'b0;
         eq_setting <= 4'h0;
      end
      else if (!locked)
      begin
         // Sweep settings, keep the one reached at end of search
         count <= count + 8'h01;
         eq_setting <= count[5:2];
         if (fast_mode || count == TRAIN_LAST[7:0])
            locked <= 1'b1;
      end
   end
endmodule // bch_trainer

// ===== src/bch_control.v
// What this block does
// - Power-down low holds device idle apart from the JTAG routing.
// - Reset low holds device in reset.
// - Reset release restores all default values.
// - Test strap high makes pins JTAG.
// - Pins one-four map to TCK TMS TDI TDO.
// - Address strap selects bus address only.
// - Receiver has two lanes and AUX.
// - Fast or full training both complete.
// - Support scrambler seed reset and enhanced framing.
// - Training searches and picks equaliser setting.
// - Native AUX services DPCD registers.
// - I2C-over-AUX forwarded to panel DDC.
// - Hot-plug low until initialisation done.
// - Hot-plug asserted after initialisation.
// - Default max lane count two at 00002h.
// - Vendor registers at base 0x00510 plus offset.
`timescale 1ns/1ps
`include "bch_regs.vh"
module bch_control
(
   input wire clock,
   input wire reset,
   input wire deep_sleep_in_low,
   input wire chip_reset_in_low,
   input wire bus_addr_strap,
   input wire scan_strap_select,
   input wire strap_pin_one,
   input wire strap_pin_two,
   input wire strap_pin_three,
   input wire strap_pin_four,
   input wire tdo_data,
   input wire aux_req,
   input wire aux_type,
   input wire aux_write,
   input wire [19:0] aux_addr,
   input wire [7:0] aux_wdata,
   input wire ddc_ack,
   input wire [7:0] ddc_rdata,
   output reg sink_hotplug_out,
   output reg strap_pin_four_out,
   output reg strap_pin_four_oe,
   output reg jtag_tck,
   output reg jtag_tms,
   output reg jtag_tdi,
   output reg active,
   output reg [3:0] cfg_latched,
   output reg addr_sel,
   output reg aux_ack,
   output reg [7:0] aux_rdata,
   output reg ddc_req,
   output reg ddc_write,
   output reg [19:0] ddc_addr,
   output reg [7:0] ddc_wdata,
   output reg [1:0] lane_count,
   output reg enh_framing,
   output reg assr_enable,
   output reg train_locked,
   output reg [3:0] eq_setting
);
   localparam ST_OFF = 4'h1;
   localparam ST_SAMPLE = 4'h2;
   localparam ST_INIT = 4'h4;
   localparam ST_RUN = 4'h8;

   reg [3:0] state;
   reg [3:0] next_state;
   reg [15:0] init_count;
   reg [7:0] max_lane;
   reg [7:0] lane_set;
   reg [7:0] train_pat;
   reg [7:0] vend_reg [0:`BCH_VEND_REGS-1];
   reg ddc_busy;
   wire hold;
   wire locked_w;
   wire [3:0] eq_w;
   wire vend_hit;
   wire [19:0] vend_off;
   wire [5:0] dec_sel;
   integer i;

   localparam [31:0] INIT_LAST = `BCH_INIT_CYC - 1;

   // Address decode for the native path, one-hot so each target is a single bit
   function [5:0] dpcd_decode;
      input [19:0] addr;
      input in_vendor;
      begin
         if (addr == `BCH_DPCD_MAX_LANE)
            dpcd_decode = 6'h01;
         else if (addr == `BCH_DPCD_LANE_SET)
            dpcd_decode = 6'h02;
         else if (addr == `BCH_DPCD_TRAIN_PAT)
            dpcd_decode = 6'h04;
         else if (addr == `BCH_DPCD_LANE_STAT)
            dpcd_decode = 6'h08;
         else if (in_vendor)
            dpcd_decode = 6'h10;
         else
            dpcd_decode = 6'h20;
      end
   endfunction

   // Either pin low forces the block, apart from the JTAG routing, back to its off state
   assign hold = reset || !deep_sleep_in_low || !chip_reset_in_low;
   assign vend_off = aux_addr - `BCH_DPCD_VEND_BASE;
   assign vend_hit = aux_addr >= `BCH_DPCD_VEND_BASE
      && vend_off < `BCH_VEND_REGS;
   assign dec_sel = dpcd_decode(aux_addr, vend_hit);

   bch_trainer u_trainer
   (
      .clock(clock),
      .run(active && !hold),
      .pattern(train_pat[1:0]),
      .fast_mode(train_pat[7]),
      .eq_setting(eq_w),
      .locked(locked_w)
   );

   always @*
   begin
      next_state = state;
      case (state)
         ST_OFF:
         begin
            next_state = ST_SAMPLE;
         end
         ST_SAMPLE:
         begin
            // One cycle for the straps to be captured
            next_state = ST_INIT;
         end
         ST_INIT:
         begin
            // Fixed wait stands in for the internal start-up work
            if (init_count == INIT_LAST[15:0])
               next_state = ST_RUN;
         end
         ST_RUN:
         begin
            next_state = ST_RUN;
         end
         default:
         begin
            next_state = ST_OFF;
         end
      endcase
   end

   always @(posedge clock)
   begin
      if (hold)
      begin
         // Everything back to defaults on release
         state <= ST_OFF;
         init_count <= 16'h0000;
         sink_hotplug_out <= 1'b0;
         active <= 1'b0;
         cfg_latched <= 4'h0;
         addr_sel <= 1'b0;
         max_lane <= `BCH_MAX_LANE_RST;
         lane_set <= 8'h00;
         train_pat <= 8'h00;
         aux_ack <= 1'b0;
         aux_rdata <= 8'h00;
         ddc_req <= 1'b0;
         ddc_write <= 1'b0;
         ddc_addr <= 20'h00000;
         ddc_wdata <= 8'h00;
         ddc_busy <= 1'b0;
         for (i = 0; i < `BCH_VEND_REGS; i = i + 1)
            vend_reg[i] <= 8'h00;
      end
      else
      begin
         state <= next_state;
         if (state == ST_SAMPLE)
         begin
            // The four pin straps are only meaningful in configuration use; the address strap is always taken
            if (!scan_strap_select)
               cfg_latched <= {strap_pin_four, strap_pin_three,
                  strap_pin_two, strap_pin_one};
            addr_sel <= bus_addr_strap;
         end
         if (state == ST_INIT)
            init_count <= init_count + 16'h0001;
         if (state == ST_RUN)
         begin
            sink_hotplug_out <= 1'b1;
            active <= 1'b1;
         end
         aux_ack <= 1'b0;
         ddc_req <= 1'b0;
         // AUX only serviced once hot-plug is up
         if (active && aux_req && !ddc_busy && !aux_ack)
         begin
            if (aux_type == `BCH_AUX_I2C)
            begin
               ddc_req <= 1'b1;
               ddc_write <= aux_write;
               ddc_addr <= aux_addr;
               ddc_wdata <= aux_wdata;
               ddc_busy <= 1'b1;
            end
            else
            begin
               aux_ack <= 1'b1;
               aux_rdata <= 8'h00;
               case (dec_sel)
                  6'h01:
                  begin
                     if (aux_write)
                        max_lane <= aux_wdata;
                     else
                        aux_rdata <= max_lane;
                  end
                  6'h02:
                  begin
                     if (aux_write)
                        lane_set <= aux_wdata;
                     else
                        aux_rdata <= lane_set;
                  end
                  6'h04:
                  begin
                     if (aux_write)
                        train_pat <= aux_wdata;
                     else
                        aux_rdata <= train_pat;
                  end
                  6'h08:
                  begin
                     // Status is read-only; writes fall away
                     aux_rdata <= {3'h0, train_locked, eq_setting};
                  end
                  6'h10:
                  begin
                     if (aux_write)
                        vend_reg[vend_off[2:0]] <= aux_wdata;
                     else
                        aux_rdata <= vend_reg[vend_off[2:0]];
                  end
                  default:
                  begin
                     // Unmapped reads give zero so the source never sees stale data
                     aux_rdata <= 8'h00;
                  end
               endcase
            end
         end
         if (ddc_busy && ddc_ack)
         begin
            ddc_busy <= 1'b0;
            aux_ack <= 1'b1;
            aux_rdata <= ddc_rdata;
         end
      end
   end

   // Registered outputs; lane count capped at the two-lane main link
   always @(posedge clock)
   begin
      if (hold)
      begin
         lane_count <= 2'h2;
         enh_framing <= 1'b0;
         assr_enable <= 1'b0;
         train_locked <= 1'b0;
         eq_setting <= 4'h0;
      end
      else
      begin
         lane_count <= (lane_set[4:0] == 5'h01 || max_lane == 8'h01) ? 2'h1 : 2'h2;
         enh_framing <= lane_set[`BCH_ENH_FRAME_BIT];
         assr_enable <= vend_reg[0][`BCH_ASSR_BIT];
         train_locked <= locked_w;
         eq_setting <= eq_w;
      end
   end

   // JTAG routing is live during reset so test access never needs the core running
   always @(posedge clock)
   begin
      jtag_tck <= scan_strap_select & strap_pin_one;
      jtag_tms <= scan_strap_select & strap_pin_two;
      jtag_tdi <= scan_strap_select & strap_pin_three;
      strap_pin_four_oe <= scan_strap_select;
      strap_pin_four_out <= scan_strap_select & tdo_data;
   end
endmodule // bch_control

// ===== tb/bch_monitor.sv
`timescale 1ns/1ps
module bch_monitor
(
   input wire clock,
   input wire reset,
   input wire deep_sleep_in_low,
   input wire chip_reset_in_low,
   input wire scan_strap_select,
   input wire strap_pin_one,
   input wire aux_req,
   input wire aux_type,
   input wire ddc_ack,
   input wire sink_hotplug_out,
   input wire strap_pin_four_oe,
   input wire jtag_tck,
   input wire active,
   input wire aux_ack,
   input wire ddc_req,
   input wire [1:0] lane_count
);
   wire hold = reset | !deep_sleep_in_low | !chip_reset_in_low;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   chk_hpd_held: assert property (hold |=> !sink_hotplug_out)
      else $error("hpd in hold");
   chk_init_wait: assert property ($fell(hold) |-> !sink_hotplug_out [*8])
      else $error("hpd early");
   chk_hpd_stays: assert property (sink_hotplug_out && !hold |=> sink_hotplug_out)
      else $error("hpd dropped");
   chk_tck_gate: assert property (1 |=> jtag_tck == $past(scan_strap_select && strap_pin_one))
      else $error("tck");
   chk_tdo_enable: assert property ($stable(scan_strap_select) |-> strap_pin_four_oe == scan_strap_select)
      else $error("tdo oe");
   chk_native_ack: assert property ($rose(aux_req) && !aux_type && active |=> aux_ack)
      else $error("no ack");
   chk_i2c_fwd: assert property ($rose(aux_req) && aux_type && active |=> ddc_req && !aux_ack)
      else $error("no ddc");
   chk_ddc_reply: assert property (ddc_ack |=> aux_ack)
      else $error("no reply");
   chk_idle_quiet: assert property (!active |-> !aux_ack && !ddc_req)
      else $error("early answer");
   chk_lane_reset: assert property (hold |=> lane_count == 2'h2)
      else $error("lane default");
endmodule // bch_monitor
bind bch_control bch_monitor u_bch_monitor (.*);

// ===== tb/bch_ddc_model.sv
`timescale 1ns/1ps
module bch_ddc_model
(
   input wire clock,
   input wire ddc_req,
   input wire [19:0] ddc_addr,
   input wire [3:0] delay,
   output reg ddc_ack,
   output reg [7:0] ddc_rdata
);
   integer n = -1;
   initial ddc_ack = 0;
   initial ddc_rdata = 8'h00;
   // Data toggles outside the ack cycle so a late sample cannot pass
   always @(posedge clock)
   begin
      ddc_ack <= 0;
      ddc_rdata <= ~ddc_rdata;
      if (ddc_req)
         n <= delay;
      else if (n > 0)
         n <= n - 1;
      else if (n == 0)
      begin
         ddc_ack <= 1;
         ddc_rdata <= ddc_addr[7:0] ^ 8'hA5;
         n <= -1;
      end
   end
endmodule // bch_ddc_model

// ===== tb/test_bch_control.sv
`timescale 1ns/1ps
module test_bch_control;
   reg clock = 0, reset = 1, deep_sleep_in_low = 1, chip_reset_in_low = 1;
   reg scan_strap_select = 0, tdo_data = 0, bus_addr_strap = 1;
   reg aux_req = 0, aux_type = 0, aux_write = 0;
   reg [3:0] pins = 4'hA, delay = 4'h0;
   reg [19:0] aux_addr = 20'h00000;
   reg [7:0] aux_wdata = 8'h00, rd;
   reg [37:0] rows [0:7];
   integer n_fail = 0, comparisons = 0, i, k;
   wire sink_hotplug_out, strap_pin_four_out, strap_pin_four_oe, jtag_tck, addr_sel;
   wire jtag_tms, jtag_tdi, active, train_locked, ddc_write;
   wire [7:0] ddc_wdata;
   wire [3:0] eq_setting;
   wire aux_ack, ddc_req, ddc_ack, enh_framing, assr_enable;
   wire [3:0] cfg_latched;
   wire [7:0] aux_rdata, ddc_rdata;
   wire [19:0] ddc_addr;
   wire [1:0] lane_count;
   wire pin4 = strap_pin_four_oe ? strap_pin_four_out : pins[3];
   always #10 clock = ~clock;
   bch_control u_bch_control (.clock(clock), .reset(reset), .deep_sleep_in_low(deep_sleep_in_low),
      .chip_reset_in_low(chip_reset_in_low), .bus_addr_strap(bus_addr_strap),
      .scan_strap_select(scan_strap_select), .strap_pin_one(pins[0]), .strap_pin_two(pins[1]),
      .strap_pin_three(pins[2]), .strap_pin_four(pin4), .tdo_data(tdo_data), .aux_req(aux_req),
      .aux_type(aux_type), .aux_write(aux_write), .aux_addr(aux_addr), .aux_wdata(aux_wdata),
      .ddc_ack(ddc_ack), .ddc_rdata(ddc_rdata), .sink_hotplug_out(sink_hotplug_out),
      .strap_pin_four_out(strap_pin_four_out), .strap_pin_four_oe(strap_pin_four_oe),
      .jtag_tck(jtag_tck), .jtag_tms(jtag_tms), .jtag_tdi(jtag_tdi), .active(active),
      .cfg_latched(cfg_latched),
      .addr_sel(addr_sel), .aux_ack(aux_ack), .aux_rdata(aux_rdata), .ddc_req(ddc_req),
      .ddc_write(ddc_write), .ddc_addr(ddc_addr), .ddc_wdata(ddc_wdata), .lane_count(lane_count),
      .enh_framing(enh_framing), .assr_enable(assr_enable), .train_locked(train_locked),
      .eq_setting(eq_setting));
   bch_ddc_model u_bch_ddc_model (.clock(clock), .ddc_req(ddc_req), .ddc_addr(ddc_addr),
      .delay(delay), .ddc_ack(ddc_ack), .ddc_rdata(ddc_rdata));
   task tally_and_finish;
   begin
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   task chk(input [7:0] seen, input [7:0] exp);
   begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
         n_fail = n_fail + 1;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task wait_hpd;
   integer j;
   begin
      for (j = 0; j < 600 && sink_hotplug_out !== 1'b1; j = j + 1)
         @(negedge clock);
      if (j == 600)
      begin
         n_fail = n_fail + 1;
         tally_and_finish;
      end
   end
   endtask
   // Request held until the ack is seen settled, dropped before the next edge
   task aux(input t, input w, input [19:0] a, input [7:0] d);
   integer j;
   begin
      @(negedge clock);
      {aux_type, aux_write, aux_addr, aux_wdata, aux_req} = {t, w, a, d, 1'b1};
      for (j = 0; j < 40 && aux_ack !== 1'b1; j = j + 1)
         @(negedge clock);
      rd = aux_rdata;
      aux_req = 0;
      if (j == 40)
      begin
         n_fail = n_fail + 1;
         tally_and_finish;
      end
      @(negedge clock);
   end
   endtask
   initial
   begin
      rows[0] = {2'b00, 20'h00002, 8'h00, 8'h02};
      rows[1] = {2'b01, 20'h00510, 8'h01, 8'h00};
      rows[2] = {2'b00, 20'h00510, 8'h00, 8'h01};
      rows[3] = {2'b00, 20'h00300, 8'h00, 8'h00};
      rows[4] = {2'b11, 20'h00050, 8'h3C, 8'h00};
      rows[5] = {2'b10, 20'h00050, 8'h00, 8'hF5};
      rows[6] = {2'b01, 20'h00101, 8'h81, 8'h00};
      rows[7] = {2'b01, 20'h00102, 8'h81, 8'h00};
      repeat (2) @(negedge clock);
      reset = 0;
      aux_req = 1;
      repeat (20) @(negedge clock);
      chk(aux_ack, 0);
      aux_req = 0;
      wait_hpd;
      chk(cfg_latched, 4'hA);
      chk(addr_sel, 1);
      chk(active, 1);
      for (i = 0; i < 8; i = i + 1)
      begin
         delay = {i[1:0], 2'b00};
         aux(rows[i][37], rows[i][36], rows[i][35:16], rows[i][15:8]);
         if (!rows[i][36]) chk(rd, rows[i][7:0]);
         if (rows[i][37]) chk(ddc_wdata, rows[i][15:8]);
         if (rows[i][37]) chk(ddc_write, rows[i][36]);
         if (rows[i][37]) chk(ddc_addr[7:0], rows[i][23:16]);
      end
      chk(assr_enable, 1);
      chk(enh_framing, 1);
      chk(lane_count, 1);
      for (k = 0; k < 2; k = k + 1)
      begin
         aux(0, 1, 20'h00102, 8'h00);
         aux(0, 1, 20'h00102, k ? 8'h01 : 8'h81);
         aux(0, 0, 20'h00202, 8'h00);
         chk(rd[4], k ? 1'b0 : 1'b1);
         repeat (70) @(negedge clock);
         aux(0, 0, 20'h00202, 8'h00);
         chk(rd[4], 1);
         chk(train_locked, 1);
         chk(eq_setting, rd[3:0]);
      end
      for (k = 0; k < 2; k = k + 1)
      begin
         {deep_sleep_in_low, chip_reset_in_low} = k ? 2'b10 : 2'b01;
         repeat (2) @(negedge clock);
         chk(sink_hotplug_out, 0);
         chk(lane_count, 2);
         {deep_sleep_in_low, chip_reset_in_low} = 2'b11;
         wait_hpd;
      end
      aux(0, 0, 20'h00510, 8'h00);
      chk(rd, 0);
      for (k = 0; k < 2; k = k + 1)
      begin
         scan_strap_select = 1;
         pins = {1'b0, k[0], k[0], k[0]};
         tdo_data = k[0];
         repeat (2) @(negedge clock);
         chk(strap_pin_four_oe, 1);
         chk(jtag_tck, k[0]);
         chk(jtag_tms, k[0]);
         chk(jtag_tdi, k[0]);
         chk(strap_pin_four_out, k[0]);
      end
      scan_strap_select = 0;
      repeat (2) @(negedge clock);
      chk(strap_pin_four_oe, 0);
      chk(jtag_tck, 0);
      tally_and_finish;
   end
endmodule // test_bch_control
